// [adc_channel_trigger_control.sv]
// Register file and trigger logic for the converter control block.
// Assumes the converter core and timer match pulses run on clk; the
// external trigger pin is asynchronous and is synchronised here.
//
// Overview of operation
// - Bit 7 of channel control switches the internal reference on or off.
// - Bit 6 zero stops the converter during processor idle; one keeps running.
// - Bit 5 picks four or eight channel scan groups; ignored in fixed mode.
// - Channel codes 0 to 11 select inputs; codes 12 and up prohibited.
// - Four-channel scan runs from group base 0, 4 or 8 to selected channel.
// - Eight-channel scan runs from 0, or from 8 for codes 8 to 11.
// - Priority done flag bit 7 sets on completion, clears on register read.
// - Priority busy flag bit 6 is one while a priority conversion runs.
// - Writing one to bit 5 launches priority conversion; bit reads zero.
// - Priority channel field selects inputs 0 to 11; 12 and up prohibited.
// - Priority source bit 7 picks external trigger or first timer match.
// - Priority hardware enable bit 6 gates the selected source.
// - Normal source bit 5 picks external trigger or second timer match.
// - Normal hardware enable bit 4 gates the selected source.
// - External trigger owned by priority conversion never starts normal conversion.
// - Writing key 10 then 01 performs a software reset.
// - Software reset restores all registers except the conversion clock select.
// - Scan select bit zero means fixed channel, one means channel scan.
// - Writing one to the normal start bit begins conversion; reads zero.
`timescale 1ns/100ps

module adc_channel_trigger_control
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic cpu_idle,
    input wire logic ext_trigger,
    input wire logic first_timer_compare0_match,
    input wire logic second_timer_compare0_match,
    input wire logic priority_conv_done,
    output adc_ctrl_pkg::core_cmd_s converter_cmd
);

    // Whole state of the block, registered as one word.
    typedef struct packed {
        logic reference_enable;
        logic idle_operation_enable;
        logic scan_width;
        logic write_zero_ref;
        adc_ctrl_pkg::channel_t channel;
        logic scan_select;
        logic [2:0] clock_select;
        logic priority_hw_source;
        logic priority_hw_enable;
        logic normal_hw_source;
        logic normal_hw_enable;
        logic priority_done_flag;
        logic priority_busy_flag;
        logic write_zero_pri;
        adc_ctrl_pkg::channel_t priority_channel;
        logic key_armed;
        logic ext_sync1;
        logic ext_sync2;
        logic ext_sync3;
        logic [6:0] settle_count;
        logic [31:0] rdata;
        adc_ctrl_pkg::core_cmd_s cmd;
    } ctrl_state_s;

    localparam ctrl_state_s STATE_RESET = '{
        channel: adc_ctrl_pkg::CHANNEL_RESET,
        priority_channel: adc_ctrl_pkg::CHANNEL_RESET,
        clock_select: adc_ctrl_pkg::CLOCK_SELECT_RESET,
        rdata: adc_ctrl_pkg::READ_ZERO,
        default: '0
    };

    ctrl_state_s state_reg;
    ctrl_state_s state_next;

    logic wr_primary;
    logic wr_ref;
    logic wr_priority;
    logic wr_trigger;
    logic wr_clock;
    logic rd_priority;
    logic ext_rise;
    logic ext_for_priority;
    logic priority_hw_trigger;
    logic normal_hw_trigger;
    logic priority_launch;
    logic normal_launch;
    logic soft_reset;
    logic [1:0] key_written;
    adc_ctrl_pkg::channel_t priority_channel_eff;

    // Address decode of the single-cycle strobes.
    assign wr_primary = reg_wr && (reg_addr == adc_ctrl_pkg::PRIMARY_MODE_OFS);
    assign wr_ref = reg_wr && (reg_addr == adc_ctrl_pkg::REF_CHANNEL_OFS);
    assign wr_priority = reg_wr && (reg_addr == adc_ctrl_pkg::PRIORITY_CTRL_OFS);
    assign wr_trigger = reg_wr && (reg_addr == adc_ctrl_pkg::TRIGGER_RESET_OFS);
    assign wr_clock = reg_wr && (reg_addr == adc_ctrl_pkg::CLOCK_SELECT_OFS);
    assign rd_priority = reg_rd && (reg_addr == adc_ctrl_pkg::PRIORITY_CTRL_OFS);
    assign key_written = reg_wdata[adc_ctrl_pkg::RESET_KEY_LSB +: 2];

    // The edge detector looks only at the second and third stages, never the first.
    assign ext_rise = state_reg.ext_sync2 && !state_reg.ext_sync3;

    // Hardware trigger selection for both conversion kinds.
    assign ext_for_priority = state_reg.priority_hw_enable && !state_reg.priority_hw_source;
    assign priority_hw_trigger = state_reg.priority_hw_enable &&
        (state_reg.priority_hw_source ? first_timer_compare0_match : ext_rise);
    assign normal_hw_trigger = state_reg.normal_hw_enable &&
        (state_reg.normal_hw_source ? second_timer_compare0_match
                                    : (ext_rise && !ext_for_priority));

    // A start written together with a new channel converts that new channel.
    // Using the stored field here would launch on the stale channel instead.
    assign priority_channel_eff = wr_priority ? reg_wdata[adc_ctrl_pkg::CHANNEL_LSB +: 4]
                                              : state_reg.priority_channel;

    // A launch on a prohibited channel code is dropped so the core never sees it.
    assign priority_launch = (priority_hw_trigger ||
        (wr_priority && reg_wdata[adc_ctrl_pkg::PRIORITY_START_BIT])) &&
        (priority_channel_eff <= adc_ctrl_pkg::CHANNEL_LAST_LEGAL);
    assign normal_launch = (normal_hw_trigger ||
        (wr_primary && reg_wdata[adc_ctrl_pkg::NORMAL_START_BIT])) &&
        (state_reg.channel <= adc_ctrl_pkg::CHANNEL_LAST_LEGAL);

    // The key must be written as 10 and then 01 in two consecutive writes to the register.
    assign soft_reset = wr_trigger && state_reg.key_armed &&
        (key_written == adc_ctrl_pkg::RESET_KEY_FIRE);

    // Next-state logic for every field of the block.
    always_comb
    begin
        state_next = state_reg;
        state_next.ext_sync1 = ext_trigger;
        state_next.ext_sync2 = state_reg.ext_sync1;
        state_next.ext_sync3 = state_reg.ext_sync2;
        state_next.rdata = adc_ctrl_pkg::READ_ZERO;
        if (wr_primary)
        begin
            state_next.scan_select = reg_wdata[adc_ctrl_pkg::SCAN_SELECT_BIT];
        end
        if (wr_ref)
        begin
            state_next.reference_enable = reg_wdata[adc_ctrl_pkg::REFERENCE_ENABLE_BIT];
            state_next.idle_operation_enable = reg_wdata[adc_ctrl_pkg::IDLE_OPERATION_BIT];
            state_next.scan_width = reg_wdata[adc_ctrl_pkg::SCAN_WIDTH_BIT];
            state_next.write_zero_ref = reg_wdata[adc_ctrl_pkg::WRITE_ZERO_BIT];
            state_next.channel = reg_wdata[adc_ctrl_pkg::CHANNEL_LSB +: 4];
        end
        if (wr_priority)
        begin
            state_next.write_zero_pri = reg_wdata[adc_ctrl_pkg::WRITE_ZERO_BIT];
            state_next.priority_channel = reg_wdata[adc_ctrl_pkg::CHANNEL_LSB +: 4];
        end
        if (wr_trigger)
        begin
            state_next.priority_hw_source = reg_wdata[adc_ctrl_pkg::PRIORITY_HW_SOURCE_BIT];
            state_next.priority_hw_enable = reg_wdata[adc_ctrl_pkg::PRIORITY_HW_ENABLE_BIT];
            state_next.normal_hw_source = reg_wdata[adc_ctrl_pkg::NORMAL_HW_SOURCE_BIT];
            state_next.normal_hw_enable = reg_wdata[adc_ctrl_pkg::NORMAL_HW_ENABLE_BIT];
            state_next.key_armed = (key_written == adc_ctrl_pkg::RESET_KEY_ARM);
        end
        if (wr_clock)
        begin
            state_next.clock_select = reg_wdata[adc_ctrl_pkg::CLOCK_SELECT_LSB +: 3];
        end

        // Busy follows the core; a finish in the launch cycle leaves busy set.
        if (state_reg.priority_busy_flag && priority_conv_done)
        begin
            state_next.priority_busy_flag = 1'b0;
        end
        if (priority_launch)
        begin
            state_next.priority_busy_flag = 1'b1;
        end

        // Reading clears the done flag, but a completion in the same cycle wins.
        if (rd_priority)
        begin
            state_next.priority_done_flag = 1'b0;
        end
        if (priority_conv_done)
        begin
            state_next.priority_done_flag = 1'b1;
        end

        // Settling counter; software is still expected to time its own wait.
        if (!state_reg.reference_enable)
        begin
            state_next.settle_count = 7'h00;
        end
        else if (state_reg.settle_count != adc_ctrl_pkg::REF_SETTLE_CYCLES)
        begin
            state_next.settle_count = state_reg.settle_count + 7'h01;
        end

        // Read data, valid in the cycle after the read strobe.
        if (reg_rd)
        begin
            unique case (reg_addr)
                adc_ctrl_pkg::PRIMARY_MODE_OFS:
                begin
                    state_next.rdata[adc_ctrl_pkg::SCAN_SELECT_BIT] = state_reg.scan_select;
                end
                adc_ctrl_pkg::REF_CHANNEL_OFS:
                begin
                    state_next.rdata[adc_ctrl_pkg::REFERENCE_ENABLE_BIT] = state_reg.reference_enable;
                    state_next.rdata[adc_ctrl_pkg::IDLE_OPERATION_BIT] = state_reg.idle_operation_enable;
                    state_next.rdata[adc_ctrl_pkg::SCAN_WIDTH_BIT] = state_reg.scan_width;
                    state_next.rdata[adc_ctrl_pkg::WRITE_ZERO_BIT] = state_reg.write_zero_ref;
                    state_next.rdata[adc_ctrl_pkg::CHANNEL_LSB +: 4] = state_reg.channel;
                end
                adc_ctrl_pkg::PRIORITY_CTRL_OFS:
                begin
                    state_next.rdata[adc_ctrl_pkg::PRIORITY_DONE_BIT] = state_reg.priority_done_flag;
                    state_next.rdata[adc_ctrl_pkg::PRIORITY_BUSY_BIT] = state_reg.priority_busy_flag;
                    state_next.rdata[adc_ctrl_pkg::WRITE_ZERO_BIT] = state_reg.write_zero_pri;
                    state_next.rdata[adc_ctrl_pkg::CHANNEL_LSB +: 4] = state_reg.priority_channel;
                end
                adc_ctrl_pkg::TRIGGER_RESET_OFS:
                begin
                    state_next.rdata[adc_ctrl_pkg::PRIORITY_HW_SOURCE_BIT] = state_reg.priority_hw_source;
                    state_next.rdata[adc_ctrl_pkg::PRIORITY_HW_ENABLE_BIT] = state_reg.priority_hw_enable;
                    state_next.rdata[adc_ctrl_pkg::NORMAL_HW_SOURCE_BIT] = state_reg.normal_hw_source;
                    state_next.rdata[adc_ctrl_pkg::NORMAL_HW_ENABLE_BIT] = state_reg.normal_hw_enable;
                end
                adc_ctrl_pkg::CLOCK_SELECT_OFS:
                begin
                    state_next.rdata[adc_ctrl_pkg::CLOCK_SELECT_LSB +: 3] = state_reg.clock_select;
                end
                default:
                begin
                    state_next.rdata = adc_ctrl_pkg::READ_ZERO;
                end
            endcase
        end

        // Commands to the core are registered from the current settings.
        state_next.cmd.reference_on = state_reg.reference_enable;
        state_next.cmd.reference_settled = state_reg.reference_enable &&
            (state_reg.settle_count == adc_ctrl_pkg::REF_SETTLE_CYCLES);
        state_next.cmd.converter_run = !(cpu_idle && !state_reg.idle_operation_enable);
        state_next.cmd.normal_start = normal_launch;
        state_next.cmd.priority_start = priority_launch;
        state_next.cmd.priority_channel = priority_channel_eff;
        state_next.cmd.scan_mode = state_reg.scan_select;
        state_next.cmd.scan_last = state_reg.channel;
        state_next.cmd.conv_clock_select = state_reg.clock_select;
        if (!state_reg.scan_select)
        begin
            state_next.cmd.scan_first = state_reg.channel;
        end
        else if (!state_reg.scan_width)
        begin
            state_next.cmd.scan_first = {state_reg.channel[3:2], 2'h0};
        end
        else
        begin
            state_next.cmd.scan_first = {state_reg.channel[3], 3'h0};
        end

        // Software reset returns everything to reset values except the clock select and the trigger synchroniser.
        if (soft_reset)
        begin
            state_next = STATE_RESET;
            state_next.clock_select = state_reg.clock_select;
            state_next.cmd.conv_clock_select = state_reg.clock_select;
            state_next.ext_sync1 = ext_trigger;
            state_next.ext_sync2 = state_reg.ext_sync1;
            state_next.ext_sync3 = state_reg.ext_sync2;
        end
    end

    // State register; asynchronous reset loads constants only.
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= STATE_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata = state_reg.rdata;
    assign converter_cmd = state_reg.cmd;

    // A completed priority conversion is visible in the following cycle unless a software reset clears it.
    a_done_sets_flag: assert property (@(posedge clk) disable iff (rst)
        (priority_conv_done && !soft_reset) |=> state_reg.priority_done_flag)
        else $error("priority done flag missed a completion");

    // A read without a new completion leaves the done flag clear afterwards.
    a_read_clears_done: assert property (@(posedge clk) disable iff (rst)
        (rd_priority && !priority_conv_done) |=> !state_reg.priority_done_flag)
        else $error("priority done flag survived a read");

    // A launch raises busy in the following cycle.
    a_busy_follows_launch: assert property (@(posedge clk) disable iff (rst)
        (priority_launch && !soft_reset) |=> state_reg.priority_busy_flag ##0
        (state_reg.priority_busy_flag || $past(priority_conv_done)))
        else $error("priority busy did not follow a launch");

    // The priority start bit never reads back as one.
    a_start_reads_zero: assert property (@(posedge clk) disable iff (rst)
        rd_priority |=> (reg_rdata[adc_ctrl_pkg::PRIORITY_START_BIT] == 1'b0) &&
        (reg_rdata[31:8] == 24'h00_0000))
        else $error("priority start bit or upper bits read as one");

    // The reference follows the written enable two edges after the write.
    a_reference_follows: assert property (@(posedge clk) disable iff (rst)
        (wr_ref && !soft_reset) |=> ##1
        (converter_cmd.reference_on == $past(reg_wdata[adc_ctrl_pkg::REFERENCE_ENABLE_BIT], 2)))
        else $error("reference output did not follow its enable");

    // The converter halts in idle unless idle operation is enabled.
    a_idle_stops_core: assert property (@(posedge clk) disable iff (rst)
        (cpu_idle && !state_reg.idle_operation_enable) |=> !converter_cmd.converter_run)
        else $error("converter kept running in idle");

    // Four-channel scan starts at the base of the selected group.
    a_scan_four_base: assert property (@(posedge clk) disable iff (rst)
        (state_reg.scan_select && !state_reg.scan_width && !soft_reset) |=>
        (converter_cmd.scan_first == {$past(state_reg.channel[3:2]), 2'h0}))
        else $error("four-channel scan base wrong");

    // An external edge owned by priority conversion never starts a normal one.
    a_ext_not_shared: assert property (@(posedge clk) disable iff (rst)
        (ext_for_priority && !state_reg.normal_hw_source && !wr_primary) |=>
        !converter_cmd.normal_start)
        else $error("external trigger started a normal conversion");

    // No normal start ever reaches the core with a prohibited channel code.
    a_no_illegal_start: assert property (@(posedge clk) disable iff (rst)
        converter_cmd.normal_start |-> ($past(state_reg.channel) <= adc_ctrl_pkg::CHANNEL_LAST_LEGAL))
        else $error("normal start issued on a prohibited channel");

    // The key sequence clears settings but keeps the conversion clock select.
    a_soft_reset_keeps: assert property (@(posedge clk) disable iff (rst)
        soft_reset |=> !state_reg.reference_enable && !state_reg.key_armed &&
        (state_reg.clock_select == $past(state_reg.clock_select)))
        else $error("software reset did not restore the registers");

    // Busy stays up until the core reports the end of the conversion.
    a_busy_holds_run: assert property (@(posedge clk) disable iff (rst)
        (state_reg.priority_busy_flag && !priority_conv_done && !soft_reset) |=> state_reg.priority_busy_flag)
        else $error("priority busy dropped before completion");

    // A priority start never reaches the core with a prohibited channel code.
    a_priority_legal_channel: assert property (@(posedge clk) disable iff (rst)
        converter_cmd.priority_start |-> (converter_cmd.priority_channel <= adc_ctrl_pkg::CHANNEL_LAST_LEGAL))
        else $error("priority start issued on a prohibited channel");

    // Fixed channel mode converts exactly the selected channel.
    a_fixed_channel_first: assert property (@(posedge clk) disable iff (rst)
        (!state_reg.scan_select && !soft_reset) |=> (converter_cmd.scan_first == $past(state_reg.channel)))
        else $error("fixed channel mode first channel wrong");

    // Eight-channel scan starts at input 0 or input 8.
    a_scan_eight_base: assert property (@(posedge clk) disable iff (rst)
        (state_reg.scan_select && state_reg.scan_width && !soft_reset) |=>
        (converter_cmd.scan_first == {$past(state_reg.channel[3]), 3'h0}))
        else $error("eight-channel scan base wrong");

    // A first timer match starts a priority conversion when enabled and selected.
    a_timer_priority_start: assert property (@(posedge clk) disable iff (rst)
        (state_reg.priority_hw_enable && state_reg.priority_hw_source && first_timer_compare0_match &&
        (priority_channel_eff <= adc_ctrl_pkg::CHANNEL_LAST_LEGAL) && !soft_reset) |=>
        converter_cmd.priority_start)
        else $error("timer match did not start a priority conversion");

    // With the hardware source disabled only a register write can start a priority conversion.
    a_priority_hw_gated: assert property (@(posedge clk) disable iff (rst)
        (!state_reg.priority_hw_enable && !wr_priority) |=> !converter_cmd.priority_start)
        else $error("disabled hardware source started a priority conversion");

    // A second timer match starts a normal conversion when enabled and selected.
    a_timer_normal_start: assert property (@(posedge clk) disable iff (rst)
        (state_reg.normal_hw_enable && state_reg.normal_hw_source && second_timer_compare0_match &&
        (state_reg.channel <= adc_ctrl_pkg::CHANNEL_LAST_LEGAL) && !soft_reset) |=>
        converter_cmd.normal_start)
        else $error("timer match did not start a normal conversion");

endmodule

// [adc_channel_trigger_control_tb_top.sv]
// Self-checking bench for the converter control block with a behavioural core.
// Assumes a 25 MHz clock; the external trigger is tied low, so no test selects it.
`timescale 1ns/100ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module adc_channel_trigger_control_tb_top;
    logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, cpu_idle = 1'b0;
    logic t1 = 1'b0, t2 = 1'b0, done;
    logic [7:0] reg_addr = 8'h00, dly = 8'h0A;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
    adc_ctrl_pkg::core_cmd_s cmd;
    int n_mismatch = 0, compares = 0;
    always #20 clk = ~clk;
    adc_channel_trigger_control u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_idle(cpu_idle), .ext_trigger(1'b0),
        .first_timer_compare0_match(t1), .second_timer_compare0_match(t2), .priority_conv_done(done),
        .converter_cmd(cmd));
    adc_core_model u_core (.clk(clk), .rst(rst), .done_delay(dly), .converter_cmd(cmd),
        .priority_conv_done(done));
    function automatic void check_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endfunction
    // Bus cycles: strobes last one cycle; results are sampled 1 ns after the taking edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    // Level fields lag their register by a cycle, so let two edges pass.
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_reset_values();
        rdr(8'h04); `CHK(rd, 0);
        rdr(8'h08); `CHK(rd, 0);
        rdr(8'h0C); `CHK(rd, 0);
        rdr(8'h14); `CHK(rd, 0);
        wr(8'h04, 32'hFFFF_FFEB); rdr(8'h04); `CHK(rd, 32'hEB);
        settle(); `CHK(cmd.reference_on, 1);
        `CHK(cmd.reference_settled, 0);
        repeat (76) @(posedge clk);
        #1 `CHK(cmd.reference_settled, 1);
        wr(8'h04, 32'h0B); settle(); `CHK(cmd.reference_on, 0);
        $display("test reset_values done");
    endtask
    task automatic t_scan();
        wr(8'h00, 32'h2);
        for (int w = 0; w < 2; w++)
            for (int c = 0; c < 12; c++)
            begin
                wr(8'h04, 32'((w << 5) | c)); settle();
                `CHK(cmd.scan_first, w ? (c >= 8 ? 8 : 0) : (c & 12));
                `CHK(cmd.scan_last, c);
            end
        wr(8'h00, 32'h3); #1 `CHK(cmd.normal_start, 1);
        settle(); `CHK(cmd.normal_start, 0);
        `CHK(cmd.scan_mode, 1);
        rdr(8'h00); `CHK(rd[1:0], 2'h2);
        wr(8'h00, 32'h0); settle(); `CHK(cmd.scan_mode, 0);
        `CHK(cmd.scan_first, 11);
        $display("test scan done");
    endtask
    task automatic t_priority();
        wr(8'h08, 32'h25); `CHK(cmd.priority_start, 1);
        `CHK(cmd.priority_channel, 5);
        rdr(8'h08); `CHK(rd, 32'h45);
        repeat (12) @(posedge clk);
        rdr(8'h08); `CHK(rd, 32'h85);
        rdr(8'h08); `CHK(rd, 32'h05);
        wr(8'h08, 32'h2C); `CHK(cmd.priority_start, 0);
        wr(8'h08, 32'h05); `CHK(cmd.priority_start, 0);
        $display("test priority done");
    endtask
    // Both source bits stay at one: the external trigger is tied low in this bench.
    task automatic t_triggers();
        dly <= 8'h01;
        wr(8'h0C, 32'hF0); rdr(8'h0C); `CHK(rd, 32'hF0);
        @(posedge clk); t1 <= 1'b1; @(posedge clk); t1 <= 1'b0;
        #1 `CHK(cmd.priority_start, 1);
        settle(); rdr(8'h08); `CHK(rd[7:6], 2'h2);
        @(posedge clk); t2 <= 1'b1; @(posedge clk); t2 <= 1'b0;
        #1 `CHK(cmd.normal_start, 1);
        wr(8'h0C, 32'hA0);
        @(posedge clk); t1 <= 1'b1; t2 <= 1'b1; @(posedge clk); t1 <= 1'b0; t2 <= 1'b0;
        #1 `CHK({cmd.priority_start, cmd.normal_start}, 0);
        $display("test triggers done");
    endtask
    task automatic t_idle_and_soft_reset();
        @(posedge clk);
        cpu_idle <= 1'b1;
        wr(8'h04, 32'h80); settle(); `CHK(cmd.converter_run, 0);
        wr(8'h04, 32'hC0); settle(); `CHK(cmd.converter_run, 1);
        @(posedge clk);
        cpu_idle <= 1'b0;
        wr(8'h10, 32'h5); wr(8'h0C, 32'hF1); rdr(8'h04); `CHK(rd, 32'hC0);
        wr(8'h0C, 32'hF2); wr(8'h0C, 32'hF1);
        rdr(8'h04); `CHK(rd, 0);
        rdr(8'h0C); `CHK(rd, 0);
        rdr(8'h10); `CHK(rd[2:0], 3'h5);
        `CHK(cmd.conv_clock_select, 3'h5);
        $display("test idle_and_soft_reset done");
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // The tests need a few hundred cycles; the watchdog allows far more.
    initial
    begin
        #400000;
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_scan();
        t_priority();
        t_triggers();
        t_idle_and_soft_reset();
        report_and_stop();
    end
endmodule

// [adc_core_model.sv]
// Behavioural converter core: answers the latest priority start with a done pulse.
// Assumes the start and done pulses share clk with the control block.
`timescale 1ns/100ps
module adc_core_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] done_delay,
    input wire adc_ctrl_pkg::core_cmd_s converter_cmd,
    output logic priority_conv_done
);
    int cnt;
    // A start seen while one is pending restarts the count, as a re-issued launch would.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt <= 0;
            priority_conv_done <= 1'b0;
        end
        else
        begin
            priority_conv_done <= (cnt == 1);
            if (converter_cmd.priority_start)
                cnt <= int'(done_delay);
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule

// [adc_ctrl_pkg.sv]
// Constants, field positions and carrier types for the converter control block.
// Assumes a 25 MHz peripheral clock and a word-aligned register port.
package adc_ctrl_pkg;

    // Register byte offsets on the plain register port.
    localparam logic [7:0] PRIMARY_MODE_OFS = 8'h00;
    localparam logic [7:0] REF_CHANNEL_OFS = 8'h04;
    localparam logic [7:0] PRIORITY_CTRL_OFS = 8'h08;
    localparam logic [7:0] TRIGGER_RESET_OFS = 8'h0C;
    localparam logic [7:0] CLOCK_SELECT_OFS = 8'h10;

    // Primary mode register fields.
    localparam int NORMAL_START_BIT = 0;
    localparam int SCAN_SELECT_BIT = 1;

    // Reference and channel control fields.
    localparam int REFERENCE_ENABLE_BIT = 7;
    localparam int IDLE_OPERATION_BIT = 6;
    localparam int SCAN_WIDTH_BIT = 5;
    localparam int WRITE_ZERO_BIT = 4;
    localparam int CHANNEL_LSB = 0;

    // Priority conversion control fields.
    localparam int PRIORITY_DONE_BIT = 7;
    localparam int PRIORITY_BUSY_BIT = 6;
    localparam int PRIORITY_START_BIT = 5;

    // Trigger and reset control fields, and the clock select field.
    localparam int PRIORITY_HW_SOURCE_BIT = 7;
    localparam int PRIORITY_HW_ENABLE_BIT = 6;
    localparam int NORMAL_HW_SOURCE_BIT = 5;
    localparam int NORMAL_HW_ENABLE_BIT = 4;
    localparam int RESET_KEY_LSB = 0;
    localparam int CLOCK_SELECT_LSB = 0;

    // Reset values and codes.
    localparam logic [1:0] RESET_KEY_ARM = 2'h2;
    localparam logic [1:0] RESET_KEY_FIRE = 2'h1;
    localparam logic [3:0] CHANNEL_LAST_LEGAL = 4'hB;
    localparam logic [3:0] CHANNEL_RESET = 4'h0;
    localparam logic [2:0] CLOCK_SELECT_RESET = 3'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // Reference settling time, rounded up to whole clock cycles.
    localparam int CLOCK_PERIOD_NS = 40;
    localparam int REF_SETTLE_NS = 3000;
    localparam logic [6:0] REF_SETTLE_CYCLES = 7'((REF_SETTLE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

    typedef logic [3:0] channel_t;

    // Commands and settings handed to the converter core.
    typedef struct packed {
        logic reference_on;
        logic reference_settled;
        logic converter_run;
        logic normal_start;
        logic scan_mode;
        channel_t scan_first;
        channel_t scan_last;
        logic priority_start;
        channel_t priority_channel;
        logic [2:0] conv_clock_select;
    } core_cmd_s;

endpackage
